// ---- hw/css_pkg.sv ----
// Purpose: Shared constants for the command set switchover block
// Assumes: 100 MHz clock, plain register port with one-cycle read data
// Notes:   Offsets are word addresses on the register port
package css_pkg;
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned SWITCH_TIME_US    = 4000;
  localparam int unsigned SWITCH_CYCLES     = SWITCH_TIME_US * CLK_MHZ;
  localparam int unsigned SETS_MAX          = 4;
  localparam int unsigned CMD_W             = 16;
  localparam logic [1:0]  SET_COUNT_RST     = 2'h2;
  localparam logic [2:0]  SET_COUNT_MIN     = 3'h2;
  localparam logic [2:0]  SET_COUNT_MAX     = 3'h4;
  localparam logic [3:0]  COMM_READY        = 4'h0;
  localparam logic [3:0]  COMM_DATA_SETS    = 4'hF;
  localparam logic [4:0]  OFS_SET_COUNT     = 5'h00;
  localparam logic [4:0]  OFS_COMM_STATE    = 5'h01;
  localparam logic [4:0]  OFS_ACTIVE_SET    = 5'h02;
  localparam logic [4:0]  OFS_COPY_SRC      = 5'h03;
  localparam logic [4:0]  OFS_COPY_DST      = 5'h04;
  localparam logic [4:0]  OFS_COPY_GO       = 5'h05;
  localparam logic [4:0]  OFS_SETPOINT_SRC  = 5'h06;
  localparam logic [4:0]  OFS_SETPOINT      = 5'h07;
  localparam logic [4:0]  OFS_SET_WORD0     = 5'h10;
  localparam logic [1:0]  SRC_AIN0          = 2'h0;
  localparam logic [1:0]  SRC_AIN1          = 2'h1;
  localparam logic [1:0]  SRC_NONE          = 2'h2;
endpackage

// ---- hw/css_sync.sv ----
// Purpose: Two-flop synchroniser for the two selection pins
// Assumes: Pins are asynchronous to clk
// Notes:   First stage is read only by the second
module css_sync (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic [1:0] d,
  output logic      [1:0] q
);
  logic [1:0] s1_r;
  logic [1:0] s1_nxt;
  logic [1:0] q_nxt;
  always_comb begin
    s1_nxt = ce ? d : s1_r;
    q_nxt  = ce ? s1_r : q;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_r <= 2'h0;
      q    <= 2'h0;
    end else begin
      s1_r <= s1_nxt;
      q    <= q_nxt;
    end
  end
endmodule // css_sync

// ---- hw/css_top.sv ----
// Purpose: Keeps command sets, selects the active one, copies sets, routes setpoint
// Assumes: Selection bits arrive on pins; analog values come from the same clock
// Notes:   Each set is one command word; the active word changes in one edge
module css_top #(
  parameter int unsigned SWITCH_CYC = css_pkg::SWITCH_CYCLES,
  parameter int unsigned CMD_W      = css_pkg::CMD_W
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic [1:0]       set_select_bit,
  input  wire logic [15:0]      analog_input_value0,
  input  wire logic [15:0]      analog_input_value1,
  input  wire logic [4:0]       addr,
  input  wire logic [31:0]      wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [31:0]      rdata,
  output logic      [1:0]       active_set_display,
  output logic      [CMD_W-1:0] command_word,
  output logic      [15:0]      main_setpoint,
  output logic                  switch_busy
);
  localparam int unsigned SW_W = $clog2(SWITCH_CYC + 1);

  typedef enum logic [1:0] {
    CSS_IDLE = 2'b00,
    CSS_WAIT = 2'b01,
    CSS_COPY = 2'b10
  } css_state_t;

  logic [1:0] sel_sync;
  css_sync u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .d     (set_select_bit),
    .q     (sel_sync)
  );

  css_state_t        st_r, st_nxt;
  logic [2:0]        count_r, count_nxt;
  logic [3:0]        comm_r, comm_nxt;
  logic [1:0]        act_r, act_nxt;
  logic [1:0]        pend_r, pend_nxt;
  logic [SW_W-1:0]   tmr_r, tmr_nxt;
  logic [1:0]        csrc_r, csrc_nxt;
  logic [1:0]        cdst_r, cdst_nxt;
  logic              cgo_r, cgo_nxt;
  logic [1:0]        spsrc_r, spsrc_nxt;
  logic [15:0]       sp_r, sp_nxt;
  logic [CMD_W-1:0]  cmd_r, cmd_nxt;
  logic              busy_r, busy_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic [CMD_W-1:0]  sets_r [css_pkg::SETS_MAX];
  logic [CMD_W-1:0]  sets_nxt [css_pkg::SETS_MAX];

  // Index the selection pins map to, limited by the configured count
  function automatic logic [1:0] css_pick(input logic [1:0] s, input logic [2:0] n);
    logic [2:0] w;
    w = {1'b0, s};
    if (n <= 3'h2) w = {2'h0, s[0]};
    if (w >= n) w = n - 3'h1;
    return w[1:0];
  endfunction

  logic [1:0] want;
  assign want = css_pick(sel_sync, count_r);

  always_comb begin
    st_nxt    = st_r;
    count_nxt = count_r;
    comm_nxt  = comm_r;
    act_nxt   = act_r;
    pend_nxt  = pend_r;
    tmr_nxt   = tmr_r;
    csrc_nxt  = csrc_r;
    cdst_nxt  = cdst_r;
    cgo_nxt   = cgo_r;
    spsrc_nxt = spsrc_r;
    sets_nxt  = sets_r;
    rdata_nxt = 32'h0;
    if (wr) begin
      unique case (addr)
        css_pkg::OFS_SET_COUNT:
          // Count is only accepted during data-set commissioning
          if (comm_r == css_pkg::COMM_DATA_SETS && wdata[2:0] >= css_pkg::SET_COUNT_MIN
              && wdata[2:0] <= css_pkg::SET_COUNT_MAX) count_nxt = wdata[2:0];
        css_pkg::OFS_COMM_STATE:   comm_nxt  = wdata[3:0];
        css_pkg::OFS_COPY_SRC:     csrc_nxt  = wdata[1:0];
        css_pkg::OFS_COPY_DST:     cdst_nxt  = wdata[1:0];
        css_pkg::OFS_COPY_GO:      if (wdata[0]) cgo_nxt = 1'b1;
        css_pkg::OFS_SETPOINT_SRC: spsrc_nxt = wdata[1:0];
        default:
          if (addr[4] && addr[3:2] == 2'h0) sets_nxt[addr[1:0]] = wdata[CMD_W-1:0];
      endcase
    end
    if (rd) begin
      unique case (addr)
        css_pkg::OFS_SET_COUNT:    rdata_nxt = {29'h0, count_r};
        css_pkg::OFS_COMM_STATE:   rdata_nxt = {28'h0, comm_r};
        css_pkg::OFS_ACTIVE_SET:   rdata_nxt = {30'h0, act_r};
        css_pkg::OFS_COPY_SRC:     rdata_nxt = {30'h0, csrc_r};
        css_pkg::OFS_COPY_DST:     rdata_nxt = {30'h0, cdst_r};
        css_pkg::OFS_COPY_GO:      rdata_nxt = {31'h0, cgo_r};
        css_pkg::OFS_SETPOINT_SRC: rdata_nxt = {30'h0, spsrc_r};
        css_pkg::OFS_SETPOINT:     rdata_nxt = {16'h0, sp_r};
        default:
          if (addr[4] && addr[3:2] == 2'h0)
            rdata_nxt = {{(32-CMD_W){1'b0}}, sets_r[addr[1:0]]};
      endcase
    end
    unique case (st_r)
      CSS_IDLE: begin
        if (cgo_r) begin
          st_nxt = CSS_COPY;
        end else if (want != act_r) begin
          st_nxt   = CSS_WAIT;
          pend_nxt = want;
          tmr_nxt  = '0;
        end
      end
      CSS_WAIT: begin
        // Fixed settle time keeps pin glitches from flipping the set
        if (want != pend_r) begin
          pend_nxt = want;
          tmr_nxt  = '0;
        end else if (tmr_r >= SW_W'(SWITCH_CYC - 1)) begin
          act_nxt = pend_r;
          st_nxt  = CSS_IDLE;
        end else begin
          tmr_nxt = tmr_r + SW_W'(1);
        end
      end
      CSS_COPY: begin
        sets_nxt[cdst_r] = sets_r[csrc_r];
        cgo_nxt = 1'b0;
        st_nxt  = CSS_IDLE;
      end
      default: st_nxt = CSS_IDLE;
    endcase
    cmd_nxt = sets_r[act_r];
    // Registered so the busy pin comes straight from a flop
    busy_nxt = (st_nxt == CSS_WAIT);
    unique case (spsrc_r)
      css_pkg::SRC_AIN0: sp_nxt = analog_input_value0;
      css_pkg::SRC_AIN1: sp_nxt = analog_input_value1;
      default:           sp_nxt = 16'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r    <= CSS_IDLE;
      count_r <= {1'b0, css_pkg::SET_COUNT_RST};
      comm_r  <= css_pkg::COMM_READY;
      act_r   <= 2'h0;
      pend_r  <= 2'h0;
      tmr_r   <= '0;
      csrc_r  <= 2'h0;
      cdst_r  <= 2'h0;
      cgo_r   <= 1'b0;
      spsrc_r <= css_pkg::SRC_NONE;
      sp_r    <= 16'h0;
      cmd_r   <= '0;
      busy_r  <= 1'b0;
      rdata_r <= 32'h0;
      for (int i = 0; i < css_pkg::SETS_MAX; i++) sets_r[i] <= '0;
    end else if (ce) begin
      st_r    <= st_nxt;
      count_r <= count_nxt;
      comm_r  <= comm_nxt;
      act_r   <= act_nxt;
      pend_r  <= pend_nxt;
      tmr_r   <= tmr_nxt;
      csrc_r  <= csrc_nxt;
      cdst_r  <= cdst_nxt;
      cgo_r   <= cgo_nxt;
      spsrc_r <= spsrc_nxt;
      sp_r    <= sp_nxt;
      cmd_r   <= cmd_nxt;
      busy_r  <= busy_nxt;
      rdata_r <= rdata_nxt;
      sets_r  <= sets_nxt;
    end
  end

  assign rdata              = rdata_r;
  assign active_set_display = act_r;
  assign command_word       = cmd_r;
  assign main_setpoint      = sp_r;
  assign switch_busy        = busy_r;

  count_range_a: assert property (@(posedge clk) disable iff (!rst_b)
    count_r >= css_pkg::SET_COUNT_MIN && count_r <= css_pkg::SET_COUNT_MAX)
    else $error("set count out of range");
  count_lock_a: assert property (@(posedge clk) disable iff (!rst_b)
    (comm_r != css_pkg::COMM_DATA_SETS) |=> $stable(count_r))
    else $error("set count changed outside commissioning");
  active_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
    act_r < count_r[1:0] || count_r == 3'h4)
    else $error("active set beyond count");
  display_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && rd && addr == css_pkg::OFS_ACTIVE_SET)
    |=> rdata == {30'h0, $past(active_set_display)})
    else $error("active set read differs from display");
  settle_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r == CSS_WAIT && ce && tmr_r == '0) |-> $stable(act_r))
    else $error("set switched before settle time");
  settle_time_a: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(act_r) |-> $past(st_r) == CSS_WAIT && $past(tmr_r) == SW_W'(SWITCH_CYC - 1))
    else $error("set switched without full settle time");
  copy_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r == CSS_COPY && ce) |=> !cgo_r && sets_r[cdst_r] == $past(sets_r[csrc_r]))
    else $error("copy not done or start not cleared");
  atomic_cmd_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce |=> command_word == $past(sets_r[act_r]))
    else $error("command word not from active set");
  setpoint_src_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && spsrc_r == css_pkg::SRC_AIN1) |=> main_setpoint == $past(analog_input_value1))
    else $error("setpoint not from analog input 1");
endmodule // css_top

// ---- tb/css_ctrl_model.sv ----
// Purpose: Outside controller that drives the two selection pins
// Assumes: Bench hands it the wanted pin pattern in the clk domain
// Notes:   Pins move only after a rising edge, like a digital input
module css_ctrl_model (
  input  wire logic       clk,
  input  wire logic [1:0] sel_req,
  output logic      [1:0] set_select_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial set_select_bit = 2'h0;
  always @(posedge clk) set_select_bit <= sel_req;
endmodule // css_ctrl_model

// ---- tb/tb_css_top.sv ----
// Purpose: Self-checking bench for the command set switchover block
// Assumes: Short settle count of 8 cycles so switching stays quick
// Notes:   ce dropped once during a settle wait; every scenario after the reset check is a task of its own
module tb_css_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst_b;
  logic        ce;
  logic [1:0]  sel_req;
  logic [1:0]  set_select_bit;
  logic [15:0] ain0;
  logic [15:0] ain1;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [1:0]  active_set_display;
  logic [15:0] command_word;
  logic [15:0] main_setpoint;
  logic        switch_busy;
  int          miscompares = 0;
  int          n_tests = 0;
  logic [31:0] rv;

  css_ctrl_model ctl_u (.clk(clk), .sel_req(sel_req), .set_select_bit(set_select_bit));
  css_top #(.SWITCH_CYC(8)) dut_u (
    .clk(clk), .rst_b(rst_b), .ce(ce), .set_select_bit(set_select_bit),
    .analog_input_value0(ain0), .analog_input_value1(ain1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .active_set_display(active_set_display), .command_word(command_word),
    .main_setpoint(main_setpoint), .switch_busy(switch_busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic end_of_test();
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic t_count();
    rd_reg(css_pkg::OFS_SET_COUNT, rv);
    chk(rv, 32'h2);
    wr_reg(css_pkg::OFS_SET_COUNT, 32'h4);
    rd_reg(css_pkg::OFS_SET_COUNT, rv);
    chk(rv, 32'h2);
    wr_reg(css_pkg::OFS_COMM_STATE, 32'hF);
    wr_reg(css_pkg::OFS_SET_COUNT, 32'h5);
    rd_reg(css_pkg::OFS_SET_COUNT, rv);
    chk(rv, 32'h2);
    wr_reg(css_pkg::OFS_SET_COUNT, 32'h4);
    wr_reg(css_pkg::OFS_COMM_STATE, 32'h0);
    rd_reg(css_pkg::OFS_SET_COUNT, rv);
    chk(rv, 32'h4);
  endtask

  // Early look catches a switch that skips the settle wait
  // Pins s must decode to set e; hold freezes the block mid-settle for that many cycles
  task automatic t_switch(input logic [1:0] s, input logic [1:0] e, input logic [15:0] w,
                          input int hold);
    int i;
    logic [1:0] prev;
    prev = active_set_display;
    wr_reg(5'(css_pkg::OFS_SET_WORD0 + e), {16'h0, w});
    sel_req <= s;
    repeat (4) @(posedge clk);
    #1 chk(32'(switch_busy), 32'h1);
    if (hold > 0) begin
      @(posedge clk);
      ce <= 1'b0;
      repeat (hold) @(posedge clk);
      ce <= 1'b1;
      #1 chk(32'(active_set_display), 32'(prev));
      chk(32'(switch_busy), 32'h1);
    end
    for (i = 0; i < 30 && active_set_display !== e; i++) begin
      @(posedge clk);
      #1;
    end
    chk(32'(active_set_display), 32'(e));
    @(posedge clk);
    #1 chk(32'(command_word), 32'(w));
    chk(32'(switch_busy), 32'h0);
    rd_reg(css_pkg::OFS_ACTIVE_SET, rv);
    chk(rv, 32'(e));
  endtask

  // Commissioning is redone before the count changes again
  task automatic t_clamp();
    wr_reg(css_pkg::OFS_COMM_STATE, 32'hF);
    wr_reg(css_pkg::OFS_SET_COUNT, 32'h3);
    wr_reg(css_pkg::OFS_COMM_STATE, 32'h0);
    rd_reg(css_pkg::OFS_SET_COUNT, rv);
    chk(rv, 32'h3);
    t_switch(2'h3, 2'h2, 16'h7E7E, 0);
  endtask

  task automatic t_copy();
    int i;
    wr_reg(5'h11, 32'hABCD);
    wr_reg(css_pkg::OFS_COPY_SRC, 32'h1);
    wr_reg(css_pkg::OFS_COPY_DST, 32'h2);
    wr_reg(css_pkg::OFS_COPY_GO, 32'h1);
    rv = 32'h1;
    for (i = 0; i < 10 && rv !== 32'h0; i++) rd_reg(css_pkg::OFS_COPY_GO, rv);
    chk(rv, 32'h0);
    rd_reg(5'h12, rv);
    chk(rv, 32'hABCD);
    chk(32'(command_word), 32'hABCD);
  endtask

  task automatic t_setpoint(input logic [1:0] src, input logic [15:0] exp);
    wr_reg(css_pkg::OFS_SETPOINT_SRC, {30'h0, src});
    repeat (3) @(posedge clk);
    #1 chk(32'(main_setpoint), 32'(exp));
    rd_reg(css_pkg::OFS_SETPOINT, rv);
    chk(rv, 32'(exp));
  endtask

  initial begin
    #100us;
    miscompares++;
    end_of_test();
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    sel_req = 2'h0;
    ain0 = 16'h1111;
    ain1 = 16'h2222;
    addr = 5'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk(32'(main_setpoint), 32'h0);
    chk(32'(active_set_display), 32'h0);
    t_switch(2'h3, 2'h1, 16'h0BEE, 0);
    @(posedge clk);
    sel_req <= 2'h1;
    t_count();
    t_switch(2'h3, 2'h3, 16'h1234, 20);
    t_switch(2'h2, 2'h2, 16'h5A5A, 0);
    t_switch(2'h1, 2'h1, 16'h0F0F, 0);
    t_clamp();
    t_copy();
    t_setpoint(css_pkg::SRC_AIN1, 16'h2222);
    t_setpoint(css_pkg::SRC_AIN0, 16'h1111);
    end_of_test();
  end
endmodule // tb_css_top
